// ---- hdl/frcd_pkg.sv ----
// shared constants for the frequency reference condition and detect block
package frcd_pkg;
    // ==========================================================
    // register map, byte addresses on the apb bus
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_MF_SEL = 8'h04;
    localparam logic [7:0] OFS_FDET_LEVEL = 8'h08;
    localparam logic [7:0] OFS_JUMP_1 = 8'h0c;
    localparam logic [7:0] OFS_JUMP_2 = 8'h10;
    localparam logic [7:0] OFS_JUMP_3 = 8'h14;
    localparam logic [7:0] OFS_JUMP_WIDTH = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1c;
    localparam logic [7:0] OFS_OFFSET_AMT = 8'h20;
    localparam logic [7:0] OFS_REF_OUT = 8'h24;

    // ==========================================================
    // field positions
    localparam int CTRL_TSRC_BIT = 0;
    localparam int CTRL_LIMIT_LSB = 4;
    localparam int CTRL_X_LSB = 8;
    localparam int CTRL_Y_LSB = 12;
    localparam int MF_SEL_A_LSB = 0;
    localparam int MF_SEL_B_LSB = 8;
    localparam int MF_SEL_C_LSB = 16;
    localparam int ST_TSRC_BIT = 1;
    localparam int ST_ERR_BIT = 2;
    localparam int ST_COUNT_LSB = 4;

    // ==========================================================
    // reset values
    localparam logic [15:0] FREQ_RST = 16'h0000;
    localparam logic [3:0] DIGIT_RST = 4'h0;
    localparam logic [7:0] MF_SEL_RST = 8'h00;
    localparam logic [3:0] LIMIT_RST = 4'h0;
    localparam logic [15:0] JUMP_WIDTH_RST = 16'h0064;

    // ==========================================================
    // codes and limits
    localparam logic [7:0] MF_FDET_GE = 8'h04;
    localparam logic [7:0] MF_FDET_LE = 8'h05;
    localparam logic [3:0] OFFX_JUMP = 4'h0;
    localparam logic [3:0] OFFX_HZ = 4'h1;
    localparam logic [3:0] OFFX_PCT = 4'h2;
    localparam logic [3:0] SIGN_ALL_NEG = 4'h8;
    localparam logic [3:0] RETRY_MAX = 4'ha;
    localparam logic [15:0] FREQ_MAX_HZ = 16'h9c40;
    localparam logic [31:0] PCT_FULL = 32'h0000_2710;

    // ==========================================================
    // timing
    localparam int CLK_HZ = 25_000_000;
    localparam int ERR_TIME_S = 1;
    localparam int ERR_CYCLES = CLK_HZ * ERR_TIME_S;
    localparam int SEC_CYCLES = CLK_HZ;
    localparam int RETRY_CLEAR_MIN = 10;
    localparam int RETRY_CLEAR_SEC = RETRY_CLEAR_MIN * 60;
endpackage

// ---- hdl/frcd_retry.sv ----
// automatic fault retry counter with its ten minute clearing timer
`timescale 1ns/1ps
module frcd_retry #(
    parameter int SEC_CYCLES = frcd_pkg::SEC_CYCLES,
    parameter int CLEAR_SEC = frcd_pkg::RETRY_CLEAR_SEC
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // fault events
    input wire logic overcurrent_fault,
    input wire logic overvoltage_fault,
    input wire logic other_fault,
    input wire logic fault_reset,
    input wire logic [3:0] limit,
    // results
    output logic restart,
    output logic [3:0] count
);
    // ==========================================================
    // state
    logic [31:0] div;
    logic [15:0] secs;
    logic timing;
    logic fault_seen;
    logic [31:0] next_div;
    logic [15:0] next_secs;
    logic next_timing;
    logic next_fault_seen;
    logic [3:0] next_count;
    logic next_restart;
    logic retry_fault;

    assign retry_fault = overcurrent_fault | overvoltage_fault;

    always_comb begin
        next_div = div;
        next_secs = secs;
        next_timing = timing;
        next_fault_seen = fault_seen;
        next_count = count;
        next_restart = 1'b0;
        // the divider restarts with each retry so the window is exact
        if (timing) begin
            if (div == 32'(SEC_CYCLES - 1)) begin
                next_div = 32'h0000_0000;
                next_secs = secs + 16'h0001;
            end else begin
                next_div = div + 32'h0000_0001;
            end
            if (secs == 16'(CLEAR_SEC)) begin
                next_timing = 1'b0;
                next_count = 4'h0; // RULE10
            end
        end
        if (fault_reset && fault_seen) begin
            next_count = 4'h0; // RULE10
            next_fault_seen = 1'b0;
            next_timing = 1'b0;
        end
        // a fresh fault outranks a clear arriving in the same cycle
        if (retry_fault || other_fault) begin
            next_fault_seen = 1'b1;
            next_timing = 1'b0;
        end
        if (retry_fault && count < limit) begin // RULE9
            next_count = count + 4'h1; // RULE8
            next_restart = 1'b1;
            next_timing = 1'b1;
            next_div = 32'h0000_0000;
            next_secs = 16'h0000;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            div <= 32'h0000_0000;
            secs <= 16'h0000;
            timing <= 1'b0;
            fault_seen <= 1'b0;
            count <= 4'h0; // RULE10
            restart <= 1'b0;
        end else begin
            div <= next_div;
            secs <= next_secs;
            timing <= next_timing;
            fault_seen <= next_fault_seen;
            count <= next_count;
            restart <= next_restart;
        end
    end
endmodule

// ---- hdl/frcd_top.sv ----
// frequency reference conditioning and supervision with apb registers
// Behaviour
// RULE1: vector mode: source select 0 uses torque, 1 uses current
// RULE2: v/f mode ignores the selector and always uses output current
// RULE3: frequency detect drives an output only for selector codes 4 or 5
// RULE4: code 4 asserts at or above level, code 5 at or below
// RULE5: a jump value of zero prohibits no band
// RULE6: jump 1 >= 2 >= 3 else error one second and values restored
// RULE7: steady reference kept out of jump bands; ramps pass through
// RULE8: retry limit 0 to 10; each retry resets detection and restarts
// RULE9: retries follow only overcurrent or overvoltage faults
// RULE10: retry count clears after ten quiet minutes, fault reset, power off
// RULE11: enabled offsets add to or subtract from the reference by inputs
// RULE12: digit 0/1 means 0.01 hz units, digit 2 0.01 percent of max
// RULE13: three values and offset selection reset to zero
// RULE14: digit 0 makes the values jumps, 1 or 2 makes them offsets
// RULE15: final offset sums the selected signed offsets, none gives zero
// RULE16: second digit encodes per offset signs, zero all positive
`timescale 1ns/1ps
module frcd_top #(
    parameter int ERR_CYCLES = frcd_pkg::ERR_CYCLES,
    parameter int SEC_CYCLES = frcd_pkg::SEC_CYCLES
) (
    // clock and reset
    input wire logic CLOCK,
    input wire logic RST_N,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // speed control core
    input wire logic CONTROL_VECTOR,
    input wire logic [15:0] FREQ_REF_IN,
    input wire logic [15:0] OUTPUT_FREQ,
    input wire logic [15:0] MAX_OUTPUT_FREQ,
    output logic [15:0] FREQ_REF_OUT,
    output logic TORQUE_SRC_CURRENT,
    // multi-function terminals
    input wire logic [2:0] OFFSET_SELECT_IN,
    output logic [2:0] MF_OUT,
    // fault handling
    input wire logic OVERCURRENT_FAULT,
    input wire logic OVERVOLTAGE_FAULT,
    input wire logic OTHER_FAULT,
    input wire logic FAULT_RESET,
    output logic RETRY_RESTART,
    output logic [3:0] RETRY_COUNT,
    output logic ERR_INDICATION
);
    // ==========================================================
    // functions
    function automatic logic fdet(input logic [7:0] sel,
                                  input logic [15:0] f,
                                  input logic [15:0] lvl);
        if (sel == frcd_pkg::MF_FDET_GE) begin // RULE3
            return f >= lvl; // RULE4
        end else if (sel == frcd_pkg::MF_FDET_LE) begin
            return f <= lvl; // RULE4
        end
        return 1'b0;
    endfunction
    // the map is one dense run of aligned words from offset zero
    function automatic logic is_reg(input logic [7:0] a);
        logic r;
        r = 1'b1;
        if (a[1:0] != 2'h0) begin
            r = 1'b0;
        end else if (a > frcd_pkg::OFS_REF_OUT) begin
            r = 1'b0;
        end
        return r;
    endfunction

    // ==========================================================
    // register state
    logic torque_detect_source_sel;
    logic [3:0] retry_attempt_limit;
    logic [3:0] offset_x;
    logic [3:0] offset_y;
    logic [7:0] mf_output_sel_a;
    logic [7:0] mf_output_sel_b;
    logic [7:0] mf_output_sel_c;
    logic [15:0] freq_detect_level;
    logic [15:0] jump_width;
    logic [15:0] jof [3];
    logic check_pending;
    logic [31:0] err_cnt;
    logic [31:0] rdata;
    logic next_tsrc;
    logic [3:0] next_limit;
    logic [3:0] next_x;
    logic [3:0] next_y;
    logic [7:0] next_sel_a;
    logic [7:0] next_sel_b;
    logic [7:0] next_sel_c;
    logic [15:0] next_level;
    logic [15:0] next_width;
    logic [15:0] next_jof [3];
    logic next_check;
    logic [31:0] next_err_cnt;
    logic [31:0] next_rdata;
    logic wr;
    logic setup;
    logic [3:0] wlimit;
    logic [3:0] wx;
    assign setup = PSEL & ~PENABLE;
    assign wr = PSEL & PENABLE & PWRITE;
    assign wlimit = PWDATA[frcd_pkg::CTRL_LIMIT_LSB +: 4];
    assign wx = PWDATA[frcd_pkg::CTRL_X_LSB +: 4];

    // ==========================================================
    // datapath signals
    logic [15:0] scaled [3];
    logic signed [18:0] offset_sum;
    logic signed [19:0] ref_sum;
    logic [15:0] jumped_ref;
    logic [15:0] ref_result;
    logic [2:0] neg;

    // ==========================================================
    // register write, jump order check and read data
    always_comb begin
        next_tsrc = torque_detect_source_sel;
        next_limit = retry_attempt_limit;
        next_x = offset_x;
        next_y = offset_y;
        next_sel_a = mf_output_sel_a;
        next_sel_b = mf_output_sel_b;
        next_sel_c = mf_output_sel_c;
        next_level = freq_detect_level;
        next_width = jump_width;
        next_jof = jof;
        next_check = 1'b0;
        next_err_cnt = err_cnt;
        next_rdata = rdata;
        if (err_cnt != 32'h0000_0000) begin
            next_err_cnt = err_cnt - 32'h0000_0001;
        end
        // order is checked one cycle after the write lands
        if (check_pending && offset_x == frcd_pkg::OFFX_JUMP) begin
            if (jof[0] < jof[1] || jof[1] < jof[2]) begin // RULE6
                next_jof = '{default: frcd_pkg::FREQ_RST};
                next_err_cnt = 32'(ERR_CYCLES);
            end
        end
        if (wr) begin
            if (PADDR == frcd_pkg::OFS_CTRL) begin
                next_tsrc = PWDATA[frcd_pkg::CTRL_TSRC_BIT];
                // saturate so the retry count never exceeds ten
                next_limit = (wlimit > frcd_pkg::RETRY_MAX) ?
                             frcd_pkg::RETRY_MAX : wlimit; // RULE8
                next_x = wx;
                next_y = PWDATA[frcd_pkg::CTRL_Y_LSB +: 4];
                if (wx != offset_x) begin
                    // a role change makes old values meaningless
                    next_jof = '{default: frcd_pkg::FREQ_RST};
                end
            end else if (PADDR == frcd_pkg::OFS_MF_SEL) begin
                next_sel_a = PWDATA[frcd_pkg::MF_SEL_A_LSB +: 8];
                next_sel_b = PWDATA[frcd_pkg::MF_SEL_B_LSB +: 8];
                next_sel_c = PWDATA[frcd_pkg::MF_SEL_C_LSB +: 8];
            end else if (PADDR == frcd_pkg::OFS_FDET_LEVEL) begin
                next_level = PWDATA[15:0];
            end else if (PADDR == frcd_pkg::OFS_JUMP_1) begin
                next_jof[0] = PWDATA[15:0];
                next_check = 1'b1;
            end else if (PADDR == frcd_pkg::OFS_JUMP_2) begin
                next_jof[1] = PWDATA[15:0];
                next_check = 1'b1;
            end else if (PADDR == frcd_pkg::OFS_JUMP_3) begin
                next_jof[2] = PWDATA[15:0];
                next_check = 1'b1;
            end else if (PADDR == frcd_pkg::OFS_JUMP_WIDTH) begin
                next_width = PWDATA[15:0];
            end
        end
        if (setup) begin
            next_rdata = 32'h0000_0000;
            if (PADDR == frcd_pkg::OFS_CTRL) begin
                next_rdata[frcd_pkg::CTRL_TSRC_BIT] = torque_detect_source_sel;
                next_rdata[frcd_pkg::CTRL_LIMIT_LSB +: 4] = retry_attempt_limit;
                next_rdata[frcd_pkg::CTRL_X_LSB +: 4] = offset_x;
                next_rdata[frcd_pkg::CTRL_Y_LSB +: 4] = offset_y;
            end else if (PADDR == frcd_pkg::OFS_MF_SEL) begin
                next_rdata[frcd_pkg::MF_SEL_A_LSB +: 8] = mf_output_sel_a;
                next_rdata[frcd_pkg::MF_SEL_B_LSB +: 8] = mf_output_sel_b;
                next_rdata[frcd_pkg::MF_SEL_C_LSB +: 8] = mf_output_sel_c;
            end else if (PADDR == frcd_pkg::OFS_FDET_LEVEL) begin
                next_rdata[15:0] = freq_detect_level;
            end else if (PADDR == frcd_pkg::OFS_JUMP_1) begin
                next_rdata[15:0] = jof[0];
            end else if (PADDR == frcd_pkg::OFS_JUMP_2) begin
                next_rdata[15:0] = jof[1];
            end else if (PADDR == frcd_pkg::OFS_JUMP_3) begin
                next_rdata[15:0] = jof[2];
            end else if (PADDR == frcd_pkg::OFS_JUMP_WIDTH) begin
                next_rdata[15:0] = jump_width;
            end else if (PADDR == frcd_pkg::OFS_STATUS) begin
                next_rdata[2:0] = MF_OUT;
                next_rdata[frcd_pkg::ST_TSRC_BIT + 2] = TORQUE_SRC_CURRENT;
                next_rdata[frcd_pkg::ST_ERR_BIT + 2] = ERR_INDICATION;
                next_rdata[frcd_pkg::ST_COUNT_LSB + 4 +: 4] = RETRY_COUNT;
            end else if (PADDR == frcd_pkg::OFS_OFFSET_AMT) begin
                next_rdata = 32'(offset_sum);
            end else if (PADDR == frcd_pkg::OFS_REF_OUT) begin
                next_rdata[15:0] = FREQ_REF_OUT;
            end
        end
    end
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            torque_detect_source_sel <= 1'b0;
            retry_attempt_limit <= frcd_pkg::LIMIT_RST;
            offset_x <= frcd_pkg::DIGIT_RST; // RULE13
            offset_y <= frcd_pkg::DIGIT_RST;
            mf_output_sel_a <= frcd_pkg::MF_SEL_RST;
            mf_output_sel_b <= frcd_pkg::MF_SEL_RST;
            mf_output_sel_c <= frcd_pkg::MF_SEL_RST;
            freq_detect_level <= frcd_pkg::FREQ_RST;
            jump_width <= frcd_pkg::JUMP_WIDTH_RST;
            jof <= '{default: frcd_pkg::FREQ_RST}; // RULE13
            check_pending <= 1'b0;
            err_cnt <= 32'h0000_0000;
            rdata <= 32'h0000_0000;
        end else begin
            torque_detect_source_sel <= next_tsrc;
            retry_attempt_limit <= next_limit;
            offset_x <= next_x;
            offset_y <= next_y;
            mf_output_sel_a <= next_sel_a;
            mf_output_sel_b <= next_sel_b;
            mf_output_sel_c <= next_sel_c;
            freq_detect_level <= next_level;
            jump_width <= next_width;
            jof <= next_jof;
            check_pending <= next_check;
            err_cnt <= next_err_cnt;
            rdata <= next_rdata;
        end
    end
    assign PRDATA = rdata;
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL & PENABLE & ~is_reg(PADDR);
    assign ERR_INDICATION = (err_cnt != 32'h0000_0000); // RULE6

    // ==========================================================
    // torque source and frequency detection
    // RULE1 RULE2
    assign TORQUE_SRC_CURRENT = ~CONTROL_VECTOR | torque_detect_source_sel;
    assign MF_OUT[0] = fdet(mf_output_sel_a, OUTPUT_FREQ, freq_detect_level);
    assign MF_OUT[1] = fdet(mf_output_sel_b, OUTPUT_FREQ, freq_detect_level);
    assign MF_OUT[2] = fdet(mf_output_sel_c, OUTPUT_FREQ, freq_detect_level);

    // ==========================================================
    // offsets
    // codes above seven keep every offset negative
    assign neg = (offset_y >= frcd_pkg::SIGN_ALL_NEG) ? 3'h7 :
                 offset_y[2:0]; // RULE16
    for (genvar i = 0; i < 3; i++) begin : g_scale
        logic [31:0] prod;
        assign prod = 32'(jof[i]) * 32'(MAX_OUTPUT_FREQ);
        // percent of maximum turned into 0.01 hz steps
        assign scaled[i] = (offset_x == frcd_pkg::OFFX_PCT) ?
                           16'(prod / frcd_pkg::PCT_FULL) : jof[i]; // RULE12
    end
    always_comb begin
        offset_sum = 19'sh00000;
        if (offset_x == frcd_pkg::OFFX_HZ ||
            offset_x == frcd_pkg::OFFX_PCT) begin // RULE14
            for (int i = 0; i < 3; i++) begin
                if (OFFSET_SELECT_IN[i] && neg[i]) begin // RULE15
                    offset_sum = offset_sum - 19'(signed'({1'b0, scaled[i]}));
                end else if (OFFSET_SELECT_IN[i]) begin // RULE15
                    offset_sum = offset_sum + 19'(signed'({1'b0, scaled[i]}));
                end
            end
        end
    end

    // ==========================================================
    // jump bands and final reference
    // the band is held on the target only; the ramp in the core still
    // sweeps through it while accelerating or decelerating
    always_comb begin
        jumped_ref = FREQ_REF_IN;
        if (offset_x == frcd_pkg::OFFX_JUMP) begin // RULE14
            for (int i = 2; i >= 0; i--) begin
                if (jof[i] != frcd_pkg::FREQ_RST && // RULE5
                    {1'b0, FREQ_REF_IN} + {1'b0, jump_width} >=
                    {1'b0, jof[i]} &&
                    {1'b0, FREQ_REF_IN} <=
                    {1'b0, jof[i]} + {1'b0, jump_width}) begin // RULE7
                    jumped_ref = (jof[i] > jump_width) ?
                                 jof[i] - jump_width : 16'h0000;
                end
            end
        end
        ref_sum = 20'(signed'({1'b0, jumped_ref})) + 20'(offset_sum); // RULE11
        if (ref_sum < 20'sh00000) begin
            ref_result = 16'h0000;
        end else if (ref_sum > 20'(signed'({1'b0, frcd_pkg::FREQ_MAX_HZ})))
        begin
            ref_result = frcd_pkg::FREQ_MAX_HZ;
        end else begin
            ref_result = ref_sum[15:0];
        end
    end
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            FREQ_REF_OUT <= 16'h0000;
        end else begin
            FREQ_REF_OUT <= ref_result;
        end
    end

    // ==========================================================
    // automatic retry
    frcd_retry #(
        .SEC_CYCLES(SEC_CYCLES),
        .CLEAR_SEC(frcd_pkg::RETRY_CLEAR_SEC)
    ) u_retry (
        .clock(CLOCK),
        .rst_n(RST_N),
        .overcurrent_fault(OVERCURRENT_FAULT),
        .overvoltage_fault(OVERVOLTAGE_FAULT),
        .other_fault(OTHER_FAULT),
        .fault_reset(FAULT_RESET),
        .limit(retry_attempt_limit),
        .restart(RETRY_RESTART),
        .count(RETRY_COUNT)
    );
endmodule

// ---- verification/frcd_monitor.sv ----
// assertion checker on the top ports of the frequency reference block
`timescale 1ns/1ps
module frcd_monitor (
    // clock and reset
    input wire logic CLOCK,
    input wire logic RST_N,
    // torque source and reference
    input wire logic CONTROL_VECTOR,
    input wire logic TORQUE_SRC_CURRENT,
    input wire logic [15:0] FREQ_REF_OUT,
    // fault handling
    input wire logic OVERCURRENT_FAULT,
    input wire logic OVERVOLTAGE_FAULT,
    input wire logic OTHER_FAULT,
    input wire logic FAULT_RESET,
    input wire logic RETRY_RESTART,
    input wire logic [3:0] RETRY_COUNT,
    input wire logic ERR_INDICATION
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_N);
    // ==========================================================
    // properties
    a_vf_uses_current: assert property (
        !CONTROL_VECTOR |-> TORQUE_SRC_CURRENT) else $error("vf not current");
    a_restart_cause: assert property (
        RETRY_RESTART |-> $past(OVERCURRENT_FAULT || OVERVOLTAGE_FAULT))
        else $error("restart without oc or ov");
    a_other_no_retry: assert property (
        OTHER_FAULT && !OVERCURRENT_FAULT && !OVERVOLTAGE_FAULT
        |=> !RETRY_RESTART) else $error("restart after other fault");
    a_restart_counts: assert property (
        RETRY_RESTART |-> RETRY_COUNT == $past(RETRY_COUNT) + 4'h1)
        else $error("restart did not count");
    a_count_max: assert property (
        RETRY_COUNT <= 4'ha) else $error("retry count above ten");
    a_reset_clears: assert property (
        FAULT_RESET && !OVERCURRENT_FAULT && !OVERVOLTAGE_FAULT
        |=> RETRY_COUNT == 4'h0) else $error("fault reset kept count");
    a_err_holds: assert property (
        $rose(ERR_INDICATION) |-> ERR_INDICATION [*8])
        else $error("error indication too short");
    a_ref_clamped: assert property (
        FREQ_REF_OUT <= 16'h9c40) else $error("reference above range");
endmodule
bind frcd_top frcd_monitor u_frcd_monitor (.*);

// ---- verification/frcd_core_model.sv ----
// behavioural speed control core: output frequency follows the reference
`timescale 1ns/1ps
module frcd_core_model #(
    parameter logic [15:0] MAX_FREQ = 16'h1770
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // conditioned reference in, actual frequency out
    input wire logic [15:0] freq_ref_out,
    output logic [15:0] output_freq,
    output logic [15:0] max_output_freq
);
    logic [15:0] next_output_freq;
    assign max_output_freq = MAX_FREQ;
    // ==========================================================
    // ramp of at most 256 a cycle: a band is crossed, never held
    always_comb begin
        next_output_freq = freq_ref_out;
        if (freq_ref_out > output_freq + 16'h0100)
            next_output_freq = output_freq + 16'h0100;
        else if (output_freq > freq_ref_out + 16'h0100)
            next_output_freq = output_freq - 16'h0100;
        if (!rst_n)
            next_output_freq = 16'h0000;
    end
    always_ff @(posedge clock) begin
        output_freq <= next_output_freq;
    end
endmodule

// ---- verification/testbench.sv ----
// self-checking bench for the frequency reference block
`timescale 1ns/1ps
module testbench;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, vec = 1'b1;
    logic oc = 1'b0, ov = 1'b0, oth = 1'b0, frst = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, tsrc, rst_o, err, bad;
    logic [15:0] ref_in = 16'h0000, out_f, max_f, ref_out;
    logic [2:0] osel = 3'h0, mf;
    logic [3:0] cnt;
    int miscompares = 0;
    int samples_checked = 0;
    frcd_top #(.ERR_CYCLES(20), .SEC_CYCLES(10)) u_frcd_top (
        .CLOCK(clock), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .CONTROL_VECTOR(vec),
        .FREQ_REF_IN(ref_in), .OUTPUT_FREQ(out_f), .MAX_OUTPUT_FREQ(max_f),
        .FREQ_REF_OUT(ref_out), .TORQUE_SRC_CURRENT(tsrc),
        .OFFSET_SELECT_IN(osel), .MF_OUT(mf), .OVERCURRENT_FAULT(oc),
        .OVERVOLTAGE_FAULT(ov), .OTHER_FAULT(oth), .FAULT_RESET(frst),
        .RETRY_RESTART(rst_o), .RETRY_COUNT(cnt), .ERR_INDICATION(err));
    frcd_core_model u_frcd_core_model (.clock(clock), .rst_n(rst_n),
        .freq_ref_out(ref_out), .output_freq(out_f), .max_output_freq(max_f));
    initial forever #20 clock = ~clock;
    task automatic test_done();
        $display("checked %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clock);
    endtask
    // one apb transfer; an idle edge first so psel never drops and rises
    // in one step between back-to-back calls
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge clock);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        for (n = 0; pready !== 1'b1 && n < 20; n++)
            @(posedge clock);
        if (n == 20) begin
            miscompares++;
            test_done();
        end
        {rd, bad} = {prdata, pslverr};
        {psel, penable} <= 2'h0;
    endtask
    // the restart pulse stands for one cycle, so look inside it
    task automatic flt(input logic [2:0] f, input logic r,
                       input logic [3:0] c);
        {oc, ov, oth} <= f;
        @(posedge clock);
        {oc, ov, oth} <= 3'h0;
        @(negedge clock);
        chk(rst_o, r);
        chk(cnt, c);
        @(posedge clock);
    endtask
    task automatic t_reset();
        apb(1'b0, frcd_pkg::OFS_CTRL, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, frcd_pkg::OFS_JUMP_3, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 8'h30, 32'h0);
        chk({rd[30:0], bad}, 32'h1);
        $display("reset test done");
    endtask
    task automatic t_tsrc();
        apb(1'b1, frcd_pkg::OFS_CTRL, 32'h1);
        wt(1);
        chk(tsrc, 32'h1);
        apb(1'b1, frcd_pkg::OFS_CTRL, 32'h0);
        wt(1);
        chk(tsrc, 32'h0);
        vec <= 1'b0;
        wt(1);
        chk(tsrc, 32'h1);
        $display("torque source test done");
    endtask
    task automatic t_fdet();
        logic [15:0] fv [3] = '{16'h07d0, 16'h03e8, 16'h01f4};
        logic [2:0] ev [3] = '{3'h1, 3'h3, 3'h2};
        apb(1'b1, frcd_pkg::OFS_MF_SEL, 32'h0504);
        apb(1'b1, frcd_pkg::OFS_FDET_LEVEL, 32'h03e8);
        for (int i = 0; i < 3; i++) begin
            ref_in <= fv[i];
            wt(40);
            chk(mf, ev[i]);
        end
        $display("frequency detect test done");
    endtask
    task automatic t_jump();
        apb(1'b1, frcd_pkg::OFS_JUMP_1, 32'h0bb8);
        apb(1'b1, frcd_pkg::OFS_JUMP_2, 32'h07d0);
        ref_in <= 16'h0802;
        wt(40);
        chk({ref_out, out_f}, {16'h076c, 16'h076c});
        ref_in <= 16'h0032;
        wt(40);
        chk(ref_out, 32'h0032);
        apb(1'b1, frcd_pkg::OFS_JUMP_3, 32'h09c4);
        wt(2);
        chk(err, 32'h1);
        apb(1'b0, frcd_pkg::OFS_JUMP_1, 32'h0);
        chk(rd, 32'h0);
        wt(25);
        chk(err, 32'h0);
        $display("jump test done");
    endtask
    task automatic t_offset();
        int e;
        apb(1'b1, frcd_pkg::OFS_CTRL, 32'h1100);
        apb(1'b1, frcd_pkg::OFS_JUMP_1, 32'h0064);
        apb(1'b1, frcd_pkg::OFS_JUMP_2, 32'h00c8);
        apb(1'b1, frcd_pkg::OFS_JUMP_3, 32'h0190);
        ref_in <= 16'h1388;
        for (int s = 0; s < 8; s++) begin
            osel <= 3'(s);
            e = 5000 - s[0] * 100 + s[1] * 200 + s[2] * 400;
            wt(3);
            chk(ref_out, 32'(e));
        end
        apb(1'b1, frcd_pkg::OFS_CTRL, 32'h8200);
        apb(1'b1, frcd_pkg::OFS_JUMP_1, 32'h03e8);
        osel <= 3'h1;
        wt(3);
        chk(ref_out, 32'h1130);
        $display("offset test done");
    endtask
    task automatic t_retry();
        apb(1'b1, frcd_pkg::OFS_CTRL, 32'h0020);
        flt(3'b100, 1'b1, 4'h1);
        flt(3'b001, 1'b0, 4'h1);
        flt(3'b010, 1'b1, 4'h2);
        flt(3'b100, 1'b0, 4'h2);
        frst <= 1'b1;
        wt(2);
        chk(cnt, 32'h0);
        frst <= 1'b0;
        flt(3'b100, 1'b1, 4'h1);
        wt(6010);
        chk(cnt, 32'h0);
        $display("retry test done");
    endtask
    initial begin
        wt(3);
        rst_n <= 1'b1;
        wt(1);
        t_reset();
        t_tsrc();
        t_fdet();
        t_jump();
        t_offset();
        t_retry();
        test_done();
    end
endmodule
